// File: verilog/sdlc_pkg.sv
// package: word layout, reset values and state codes of the serial DAC loader
package sdlc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // serial word layout
  localparam int WORD_BITS  = 16;  // one frame carries one word
  localparam int REC_BITS   = 17;  // word plus the auto-update flag
  localparam int AUTO_POS   = 16;  // flag position in the crossing record
  localparam int CTRL_POS   = 15;  // 1 = control word, 0 = data word
  localparam int CH_LSB     = 12;  // channel select field
  localparam int CH_W       = 3;
  localparam int OP_POS     = 11;  // control: 0 = channel config, 1 = sub-DAC
  localparam int DATA_LSB   = 0;
  localparam int REF_POS    = 0;   // channel config: external reference select
  localparam int CLRLOW_POS = 1;   // channel config: clear to low code
  localparam int SUB_LSB    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // widths and depths
  localparam int DAC_BITS   = 10;
  localparam int SUB_BITS   = 8;
  localparam int CH_MAX     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_BITS   = 4;
  localparam logic [CNT_BITS-1:0] LAST_BIT = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // reset and clear values
  localparam logic [DAC_BITS-1:0] DAC_RST        = 10'h200;
  localparam logic [DAC_BITS-1:0] CLEAR_MID_CODE = 10'h200;
  localparam logic [DAC_BITS-1:0] CLEAR_LOW_CODE = 10'h000;
  localparam logic [SUB_BITS-1:0] SUB_RST        = 8'h00;

  // drain side states
  typedef enum logic [1:0] {
    SD_IDLE  = 2'b00,
    SD_CLEAR = 2'b01,
    SD_SLEEP = 2'b10
  } sdlc_drain_type;

endpackage : sdlc_pkg

// File: verilog/sdlc_stream_if.sv
// interface: valid/ready word stream between the loader's modules
`timescale 1ns/100ps
`default_nettype none
interface sdlc_stream_if #(
  parameter int WIDTH = 17
) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : sdlc_stream_if
`default_nettype wire

// File: verilog/sdlc_fifo.sv
// module: flip-flop fifo for received words
`timescale 1ns/100ps
`default_nettype none
module sdlc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic     clk_sys_in,
  input  wire logic     rst_in,
  sdlc_stream_if.sink   wr_if,
  sdlc_stream_if.source rd_if
);
  localparam int AW = $clog2(DEPTH);

  // pointer arithmetic needs a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [DEPTH-1:0][WIDTH-1:0] mem_q;
  logic [AW:0]                 wr_ptr_q;
  logic [AW:0]                 rd_ptr_q;
  wire                         full_w;
  wire                         empty_w;
  wire                         push_w;
  wire                         pop_w;

  ////////////////////////////////////////////////////////////////////////////
  // flags from the extra wrap bit
  assign full_w      = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty_w     = (wr_ptr_q == rd_ptr_q);
  assign push_w      = wr_if.valid && !full_w;
  assign pop_w       = rd_if.ready && !empty_w;
  assign wr_if.ready = !full_w;
  assign rd_if.valid = !empty_w;
  assign rd_if.data  = mem_q[rd_ptr_q[AW-1:0]];

  // storage, no reset needed: empty flag masks stale words
  always_ff @(posedge clk_sys_in) begin
    if (push_w) mem_q[wr_ptr_q[AW-1:0]] <= wr_if.data;
  end

  // pointers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push_w) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop_w)  rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  property p_no_overrun;
    @(posedge clk_sys_in) disable iff (rst_in)
    full_w && wr_if.valid && !pop_w |=> $stable(wr_ptr_q);
  endproperty
  a_no_overrun: assert property (p_no_overrun)
    else $error("fifo write pointer moved while full");
endmodule : sdlc_fifo
`default_nettype wire

// File: verilog/sdlc_top.sv
// module: serial load and control logic of a quad/octal 10-bit DAC
// Operation
// - power-down pin low puts the part in low power until it rises
// - frame sync low opens a frame; shift register works only then
// - serial data sampled into the shift register on each falling clock edge
// - each frame carries exactly one 16-bit word, all sixteen bits shifted
// - load strobe low copies all data registers into the DAC registers
// - load strobe low at sixteenth falling edge updates DACs after that word
// - clear pin low forces every main DAC to the mid code, unclocked; its per-channel cleared code follows
// - the same clear resets every offset sub-DAC
// - external reference is used for a channel only when selected
`timescale 1ns/100ps
`default_nettype none
module sdlc_top #(
  parameter int NUM_CHANNELS = 8
) (
  input  wire logic                                           clk_sys_in,
  input  wire logic                                           rst_in,
  input  wire logic                                           serial_clock_in,
  input  wire logic                                           frame_sync_n_in,
  input  wire logic                                           serial_data_in,
  input  wire logic                                           load_strobe_n_in,
  input  wire logic                                           async_clear_n_in,
  input  wire logic                                           power_down_n_in,
  output logic [NUM_CHANNELS*sdlc_pkg::DAC_BITS-1:0]          dac_code_out,
  output logic [NUM_CHANNELS*sdlc_pkg::SUB_BITS-1:0]          sub_offset_out,
  output logic [NUM_CHANNELS-1:0]                             ref_select_out,
  output logic                                                low_power_out,
  output logic                                                fifo_overflow_out
);

  // quad and octal parts only
  if (NUM_CHANNELS != 4 && NUM_CHANNELS != sdlc_pkg::CH_MAX) begin : g_bad_channels
    $error("channel count must be 4 or 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // link domain
  logic [1:0]                          lrst_q;
  wire                                 link_rst_w;
  logic [sdlc_pkg::WORD_BITS-1:0]      shift_q;
  logic [sdlc_pkg::CNT_BITS-1:0]       count_q;
  logic [sdlc_pkg::REC_BITS-1:0]       rec_q;
  logic                                tog_q;
  wire                                 last_bit_w;
  wire  [sdlc_pkg::WORD_BITS-1:0]      shift_next_w;

  // system domain
  logic [2:0]                          tsync_q;
  logic [1:0]                          ld_sync_q;
  logic [1:0]                          clr_sync_q;
  logic [1:0]                          pd_sync_q;
  wire                                 new_word_w;
  logic                                push_q;
  logic [sdlc_pkg::REC_BITS-1:0]       push_data_q;
  logic                                overflow_q;
  logic                                low_power_q;
  sdlc_pkg::sdlc_drain_type            state_q;
  sdlc_pkg::sdlc_drain_type            state_d;

  logic [NUM_CHANNELS-1:0][sdlc_pkg::DAC_BITS-1:0] data_q;
  logic [NUM_CHANNELS-1:0][sdlc_pkg::DAC_BITS-1:0] data_d;
  logic [NUM_CHANNELS-1:0][sdlc_pkg::DAC_BITS-1:0] dac_q;
  logic [NUM_CHANNELS-1:0][sdlc_pkg::DAC_BITS-1:0] clr_code_w;
  logic [NUM_CHANNELS-1:0][sdlc_pkg::SUB_BITS-1:0] sub_q;
  logic [NUM_CHANNELS-1:0]                         ref_q;
  logic [NUM_CHANNELS-1:0]                         clrlow_q;

  // drained word decode
  wire  [sdlc_pkg::REC_BITS-1:0]       word_w;
  wire                                 pop_w;
  wire  [sdlc_pkg::CH_W-1:0]           ch_w;
  wire                                 ch_ok_w;
  wire                                 wr_data_w;
  wire                                 wr_cfg_w;
  wire                                 wr_sub_w;
  wire                                 auto_pop_w;
  wire                                 ld_low_w;
  wire                                 load_now_w;

  sdlc_stream_if #(.WIDTH(sdlc_pkg::REC_BITS)) wr_bus ();
  sdlc_stream_if #(.WIDTH(sdlc_pkg::REC_BITS)) rd_bus ();

  // channel field of a word, shared by every decode path
  function automatic logic [sdlc_pkg::CH_W-1:0] chan_of(
    input logic [sdlc_pkg::REC_BITS-1:0] w
  );
    chan_of = w[sdlc_pkg::CH_LSB +: sdlc_pkg::CH_W];
  endfunction : chan_of

  ////////////////////////////////////////////////////////////////////////////
  // link domain, runs on the falling edge of the serial clock

  // reset into the link domain; the serial clock may stop between frames
  always_ff @(negedge serial_clock_in) begin
    lrst_q <= {lrst_q[0], rst_in};
  end
  assign link_rst_w = lrst_q[1];

  assign shift_next_w = {shift_q[sdlc_pkg::WORD_BITS-2:0], serial_data_in};
  assign last_bit_w   = (count_q == sdlc_pkg::LAST_BIT);

  // shifter and bit count move only inside a frame
  always_ff @(negedge serial_clock_in) begin
    if (link_rst_w) begin
      shift_q <= '0;
      count_q <= '0;
    end else if (!frame_sync_n_in) begin
      shift_q <= shift_next_w;
      count_q <= count_q + 1'b1;
    end
  end

  // whole word plus load strobe level, handed over by a toggle
  always_ff @(negedge serial_clock_in) begin
    if (link_rst_w) begin
      rec_q <= '0;
      tog_q <= 1'b0;
    end else if (!frame_sync_n_in && last_bit_w) begin
      rec_q <= {!load_strobe_n_in, shift_next_w};
      tog_q <= !tog_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the system clock

  // rec_q is stable for sixteen serial clocks after the toggle, ample to read
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tsync_q    <= '0;
      ld_sync_q  <= 2'b11;
      clr_sync_q <= 2'b11;
      pd_sync_q  <= 2'b11;
    end else begin
      tsync_q    <= {tsync_q[1:0], tog_q};
      ld_sync_q  <= {ld_sync_q[0], load_strobe_n_in};
      clr_sync_q <= {clr_sync_q[0], async_clear_n_in};
      pd_sync_q  <= {pd_sync_q[0], power_down_n_in};
    end
  end
  assign new_word_w = tsync_q[2] ^ tsync_q[1];

  // push stage; the link cannot stall, so a full fifo drops and flags
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      push_q      <= 1'b0;
      push_data_q <= '0;
      overflow_q  <= 1'b0;
    end else begin
      push_q      <= new_word_w;
      push_data_q <= new_word_w ? rec_q : push_data_q;
      overflow_q  <= overflow_q || (push_q && !wr_bus.ready);
    end
  end

  assign wr_bus.valid = push_q;
  assign wr_bus.data  = push_data_q;

  sdlc_fifo #(
    .WIDTH (sdlc_pkg::REC_BITS),
    .DEPTH (sdlc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_if      (wr_bus),
    .rd_if      (rd_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // drain control: clear and power-down stall the fifo

  always_comb begin
    if (!clr_sync_q[1]) begin
      state_d = sdlc_pkg::SD_CLEAR;
    end else if (!pd_sync_q[1]) begin
      state_d = sdlc_pkg::SD_SLEEP;
    end else begin
      state_d = sdlc_pkg::SD_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) state_q <= sdlc_pkg::SD_IDLE;
    else        state_q <= state_d;
  end

  // power-down level, held while the pin stays low
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) low_power_q <= 1'b0;
    else        low_power_q <= !pd_sync_q[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // word decode

  assign rd_bus.ready = (state_q == sdlc_pkg::SD_IDLE);
  assign pop_w        = rd_bus.valid && rd_bus.ready;
  assign word_w       = rd_bus.data;
  assign ch_w         = chan_of(word_w);
  assign ch_ok_w      = (32'(ch_w) < NUM_CHANNELS);
  assign wr_data_w    = pop_w && ch_ok_w && !word_w[sdlc_pkg::CTRL_POS];
  assign wr_cfg_w     = pop_w && ch_ok_w && word_w[sdlc_pkg::CTRL_POS]
                        && !word_w[sdlc_pkg::OP_POS];
  assign wr_sub_w     = pop_w && ch_ok_w && word_w[sdlc_pkg::CTRL_POS]
                        && word_w[sdlc_pkg::OP_POS];
  assign auto_pop_w   = wr_data_w && word_w[sdlc_pkg::AUTO_POS];
  assign ld_low_w     = !ld_sync_q[1];
  assign load_now_w   = ld_low_w || auto_pop_w;

  // next data registers, one channel written per word
  always_comb begin
    data_d = data_q;
    if (wr_data_w) data_d[ch_w] = word_w[sdlc_pkg::DATA_LSB +: sdlc_pkg::DAC_BITS];
  end

  // cleared code per channel: bias or the low level
  always_comb begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      clr_code_w[i] = clrlow_q[i] ? sdlc_pkg::CLEAR_LOW_CODE : sdlc_pkg::CLEAR_MID_CODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // data registers, first rank of the double buffer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) data_q <= {NUM_CHANNELS{sdlc_pkg::DAC_RST}};
    else        data_q <= data_d;
  end

  // dac registers; the pin clears them at once, per-channel code follows
  always_ff @(posedge clk_sys_in or negedge async_clear_n_in) begin
    if (!async_clear_n_in) begin
      dac_q <= {NUM_CHANNELS{sdlc_pkg::CLEAR_MID_CODE}};
    end else if (rst_in) begin
      dac_q <= {NUM_CHANNELS{sdlc_pkg::DAC_RST}};
    end else if (state_q == sdlc_pkg::SD_CLEAR) begin
      dac_q <= clr_code_w;
    end else if (load_now_w) begin
      dac_q <= data_d;
    end
  end

  // offset sub-DACs share the clear so transfer stays on the bias point
  always_ff @(posedge clk_sys_in or negedge async_clear_n_in) begin
    if (!async_clear_n_in) begin
      sub_q <= {NUM_CHANNELS{sdlc_pkg::SUB_RST}};
    end else if (rst_in || state_q == sdlc_pkg::SD_CLEAR) begin
      sub_q <= {NUM_CHANNELS{sdlc_pkg::SUB_RST}};
    end else if (wr_sub_w) begin
      sub_q[ch_w] <= word_w[sdlc_pkg::SUB_LSB +: sdlc_pkg::SUB_BITS];
    end
  end

  // channel config: reference choice and clear level
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ref_q    <= '0;
      clrlow_q <= '0;
    end else if (wr_cfg_w) begin
      ref_q[ch_w]    <= word_w[sdlc_pkg::REF_POS];
      clrlow_q[ch_w] <= word_w[sdlc_pkg::CLRLOW_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign dac_code_out      = dac_q;
  assign sub_offset_out    = sub_q;
  assign ref_select_out    = ref_q;
  assign low_power_out     = low_power_q;
  assign fifo_overflow_out = overflow_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_power_down;
    @(posedge clk_sys_in) disable iff (rst_in)
    !power_down_n_in [*3] |=> low_power_out;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("low power not entered after power-down held");

  property p_power_up;
    @(posedge clk_sys_in) disable iff (rst_in)
    power_down_n_in [*3] |=> !low_power_out;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("low power kept after power-down released");

  property p_frame_idle;
    @(negedge serial_clock_in) disable iff (link_rst_w)
    frame_sync_n_in |=> $stable(count_q) && $stable(shift_q) && $stable(tog_q);
  endproperty
  a_frame_idle: assert property (p_frame_idle)
    else $error("shifter moved outside a frame");

  property p_frame_shift;
    @(negedge serial_clock_in) disable iff (link_rst_w)
    !frame_sync_n_in |=> count_q == $past(count_q) + 1'b1;
  endproperty
  a_frame_shift: assert property (p_frame_shift)
    else $error("bit count did not advance in a frame");

  property p_sample;
    @(negedge serial_clock_in) disable iff (link_rst_w)
    !frame_sync_n_in |=> shift_q[0] == $past(serial_data_in)
                         && shift_q[sdlc_pkg::WORD_BITS-1:1] == $past(shift_q[14:0]);
  endproperty
  a_sample: assert property (p_sample)
    else $error("serial data not shifted in");

  property p_word_end;
    @(negedge serial_clock_in) disable iff (link_rst_w)
    !frame_sync_n_in && count_q == sdlc_pkg::LAST_BIT
      |=> tog_q != $past(tog_q) && count_q == '0
          && rec_q[sdlc_pkg::WORD_BITS-1:0] == shift_q;
  endproperty
  a_word_end: assert property (p_word_end)
    else $error("sixteenth bit did not complete the word");

  property p_auto_flag;
    @(negedge serial_clock_in) disable iff (link_rst_w)
    !frame_sync_n_in && count_q == sdlc_pkg::LAST_BIT
      |=> rec_q[sdlc_pkg::AUTO_POS] == !$past(load_strobe_n_in);
  endproperty
  a_auto_flag: assert property (p_auto_flag)
    else $error("load strobe not caught at the sixteenth edge");

  property p_load_copy;
    @(posedge clk_sys_in) disable iff (rst_in || !async_clear_n_in)
    state_q != sdlc_pkg::SD_CLEAR && !load_strobe_n_in [*3]
      |=> dac_q == $past(data_q, 1) || dac_q == data_q;
  endproperty
  a_load_copy: assert property (p_load_copy)
    else $error("dac registers do not follow data with load strobe low");

  property p_auto_load;
    @(posedge clk_sys_in) disable iff (rst_in || !async_clear_n_in)
    auto_pop_w && state_q == sdlc_pkg::SD_IDLE |=> dac_q == data_q;
  endproperty
  a_auto_load: assert property (p_auto_load)
    else $error("automatic update missed");

  property p_clear_code;
    @(posedge clk_sys_in) disable iff (rst_in)
    state_q == sdlc_pkg::SD_CLEAR && async_clear_n_in |=> dac_q == $past(clr_code_w);
  endproperty
  a_clear_code: assert property (p_clear_code)
    else $error("dac not at cleared code during clear");

  property p_clear_now;
    @(posedge clk_sys_in) disable iff (rst_in)
    !async_clear_n_in |-> dac_q == {NUM_CHANNELS{sdlc_pkg::CLEAR_MID_CODE}}
                          && sub_q == '0;
  endproperty
  a_clear_now: assert property (p_clear_now)
    else $error("clear pin did not act at once");

  property p_ref_select;
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_cfg_w |=> ref_select_out[$past(ch_w)] == $past(word_w[sdlc_pkg::REF_POS]);
  endproperty
  a_ref_select: assert property (p_ref_select)
    else $error("reference select not taken from control word");

endmodule : sdlc_top
`default_nettype wire

// File: tb/sdlc_host_model.sv
// host model: drives framed serial words toward the loader
`timescale 1ns/100ps
`default_nettype none
module sdlc_host_model (
  output logic sclk_out,
  output logic fs_n_out,
  output logic sdata_out
);
  ////////////////////////////////////////////////////////////////////////////
  // clock parked high, frame closed
  initial begin
    sclk_out  = 1'b1;
    fs_n_out  = 1'b1;
    sdata_out = 1'b0;
  end

  // clocking with frame closed; data toggles so stale bits never look valid
  task automatic idle(input int n);
    repeat (n) begin
      #7.5 sclk_out = 1'b0;
      #7.5 sclk_out = 1'b1;
      sdata_out = ~sdata_out;
    end
  endtask : idle

  // one frame, msb first, sixteen falling edges, odd offset from system clock
  task automatic send(input logic [15:0] w);
    #3.3 fs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdata_out = w[i];
      #7.5 sclk_out = 1'b0;
      #7.5 sclk_out = 1'b1;
    end
    fs_n_out  = 1'b1;
    sdata_out = ~w[0];  // released line must not keep the last bit
  endtask : send
endmodule : sdlc_host_model
`default_nettype wire

// File: tb/sdlc_top_bench.sv
// bench: serial loader driven by the host model, self-checking
`timescale 1ns/100ps
`default_nettype none
module sdlc_top_bench;
  localparam int NCH = 8;
  localparam int DB  = sdlc_pkg::DAC_BITS;
  localparam int SB  = sdlc_pkg::SUB_BITS;
  logic            clk_sys = 1'b0;
  logic            rst;
  logic            ld_n;
  logic            clr_n;
  logic            pd_n;
  wire logic       sclk;
  wire logic       fs_n;
  wire logic       sdat;
  logic [NCH*DB-1:0] dac;
  logic [NCH*SB-1:0] sub;
  logic [NCH-1:0]  refs;
  logic            lp;
  logic            ovf;
  int              fail_count = 0;
  int              check_count = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock and instances
  always #4 clk_sys = ~clk_sys;

  sdlc_host_model sdlc_host_model_inst (.sclk_out(sclk), .fs_n_out(fs_n), .sdata_out(sdat));

  sdlc_top #(.NUM_CHANNELS(NCH)) sdlc_top_inst (
    .clk_sys_in(clk_sys), .rst_in(rst), .serial_clock_in(sclk),
    .frame_sync_n_in(fs_n), .serial_data_in(sdat), .load_strobe_n_in(ld_n),
    .async_clear_n_in(clr_n), .power_down_n_in(pd_n), .dac_code_out(dac),
    .sub_offset_out(sub), .ref_select_out(refs), .low_power_out(lp),
    .fifo_overflow_out(ovf));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : clks

  function automatic logic [15:0] dch(input int i);
    return {6'h00, dac[i*DB +: DB]};
  endfunction : dch

  function automatic logic [15:0] sch(input int i);
    return {8'h00, sub[i*SB +: SB]};
  endfunction : sch

  // strobe held long enough to pass the two-flop synchroniser
  task automatic pulse_ld();
    @(posedge clk_sys) ld_n <= 1'b0;
    clks(4);
    ld_n <= 1'b1;
    clks(4);
  endtask : pulse_ld

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_load();
    sdlc_host_model_inst.send(16'h03ff);
    sdlc_host_model_inst.send(16'h3155);  // back to back frames
    clks(20);
    check("dac0 held", dch(0), 16'h0200);
    pulse_ld();
    check("dac0", dch(0), 16'h03ff);
    check("dac3", dch(3), 16'h0155);
    $display("load test done");
  endtask : t_load

  // strobe low only around the sixteenth edge, released before data lands
  task automatic t_auto();
    fork
      sdlc_host_model_inst.send(16'h7001);
      begin
        repeat (15) @(negedge sclk);
        @(posedge clk_sys) ld_n <= 1'b0;
        @(negedge sclk);
        @(posedge clk_sys) ld_n <= 1'b1;
      end
    join
    clks(20);
    check("dac7 auto", dch(7), 16'h0001);
    check("dac0 kept", dch(0), 16'h03ff);
    $display("auto test done");
  endtask : t_auto

  // stray clocks with frame closed must not shift or count
  task automatic t_ignore();
    sdlc_host_model_inst.idle(5);
    sdlc_host_model_inst.send(16'h10aa);
    clks(20);
    pulse_ld();
    check("dac1 aligned", dch(1), 16'h00aa);
    $display("ignore test done");
  endtask : t_ignore

  task automatic t_config();
    sdlc_host_model_inst.send(16'ha001);
    sdlc_host_model_inst.send(16'h985a);
    sdlc_host_model_inst.send(16'h8002);
    clks(20);
    check("ref select", {8'h00, refs}, 16'h0004);
    check("sub1", sch(1), 16'h005a);
    $display("config test done");
  endtask : t_config

  task automatic t_clear();
    @(posedge clk_sys) clr_n <= 1'b0;
    #1;
    check("dac0 async", dch(0), 16'h0200);
    check("sub1 async", sch(1), 16'h0000);
    clks(6);
    check("dac0 pin held", dch(0), 16'h0200);
    check("sub1", sch(1), 16'h0000);
    clr_n <= 1'b1;
    clks(6);
    // per-channel code lands while the synced clear drains out
    check("dac0 low", dch(0), 16'h0000);
    check("dac3 mid", dch(3), 16'h0200);
    clks(4);
    check("dac0 after", dch(0), 16'h0000);
    $display("clear test done");
  endtask : t_clear

  // power-down stalls the drain; nine words overrun the eight-word fifo
  task automatic t_power();
    @(posedge clk_sys) pd_n <= 1'b0;
    clks(4);
    check("low power", {15'h0, lp}, 16'h0001);
    for (int k = 1; k <= 9; k++)
      sdlc_host_model_inst.send(16'h4000 | k[15:0]);
    clks(10);
    check("overflow", {15'h0, ovf}, 16'h0001);
    check("dac4 stalled", dch(4), 16'h0200);
    @(posedge clk_sys) pd_n <= 1'b1;
    clks(30);
    check("awake", {15'h0, lp}, 16'h0000);
    pulse_ld();
    check("dac4 last", dch(4), 16'h0008);
    $display("power test done");
  endtask : t_power

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst   = 1'b1;
    ld_n  = 1'b1;
    clr_n = 1'b1;
    pd_n  = 1'b1;
    fork
      sdlc_host_model_inst.idle(3);
    join_none
    clks(5);
    rst <= 1'b0;
    clks(2);
    sdlc_host_model_inst.idle(4);
    check("reset low power", {15'h0, lp}, 16'h0000);
    t_load();
    t_auto();
    t_ignore();
    t_config();
    t_clear();
    t_power();
    end_sim();
  end

  // watchdog well past the expected few microseconds
  initial begin
    #100000;
    fail_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_sim();
  end
endmodule : sdlc_top_bench
`default_nettype wire
